// ### autoneg_advertisement_register.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// Advertisement register bank with its restart control and negotiation status.
// Software edits the pending advertisement freely; the link only sees it after
// a restart, so a half-finished edit never leaks onto the wire.
module autoneg_advertisement_register (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [4:0]                  regAddr,
  input  wire logic [15:0]                 regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [15:0]                 regRdData,
  input  wire logic [3:0]                  partnerAbility,
  output logic                             restartNeg,
  output logic      [15:0]                 appliedAdvert,
  output autoneg_adv_pkg::link_mode_t      resolvedMode,
  output logic                             resolvedValid
);

  // Writable advertisement bits; read-only bits are never stored
  logic [15:0] advStore;
  logic [15:0] next_advStore;

  // Restart pulse, also the read value of the control restart bit
  logic        next_restartNeg;

  // Registered read data, valid one cycle after the read strobe
  logic [15:0] next_regRdData;

  // Visible advertisement word, as software reads it
  logic [15:0] advView;

  // Decoded write strobes
  logic        wrAdv;
  logic        wrCtrl;

  // Link between the register side and the apply stage
  adv_link_if lnk ();

  // Address match, shared by the write and read decoders
  function automatic logic hitAddr(input logic [4:0] addr, input logic [4:0] target);
    return addr == target;
  endfunction

  // Apply stage: holds the word offered to the partner
  adv_apply applyStage (
    .clk (clk),
    .rst (rst),
    .lnk (lnk)
  );

  // Pending word and restart go out through the interface
  assign lnk.pendingAdvert  = advView;
  assign lnk.restart        = restartNeg;
  assign lnk.partnerAbility = partnerAbility;

  // Outputs are the apply stage flip-flops, no logic in between
  assign appliedAdvert = lnk.appliedAdvert;
  assign resolvedMode  = lnk.resolvedMode;
  assign resolvedValid = lnk.resolvedValid;

  // Software view: fixed bits merged with the stored writable ones
  assign advView = autoneg_adv_pkg::composeAdvert(advStore);

  // Write strobe decode
  assign wrAdv  = regWr && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR);
  assign wrCtrl = regWr && hitAddr(regAddr, autoneg_adv_pkg::CTRL_ADDR);

  // Advertisement next value
  always_comb
  begin
    next_advStore = advStore;
    if (wrAdv)
    begin
      // Only abilities and remote fault take the write; the mask drops the rest
      next_advStore = regWrData & autoneg_adv_pkg::ADV_WRITE_MASK;
    end
  end

  // Advertisement register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Abilities all offered, remote fault clear
      advStore <= autoneg_adv_pkg::ADV_RESET & autoneg_adv_pkg::ADV_WRITE_MASK;
    end
    else
    begin
      advStore <= next_advStore;
    end
  end

  // Restart next value
  always_comb
  begin
    // Self-clearing: a written one becomes exactly one pulse
    // A zero in the restart bit is a no-op, so other control writes do no harm
    next_restartNeg = 1'b0;
    if (wrCtrl)
    begin
      next_restartNeg = regWrData[autoneg_adv_pkg::RESTART_POS];
    end
  end

  // Restart register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      restartNeg <= 1'b0;
    end
    else
    begin
      restartNeg <= next_restartNeg;
    end
  end

  // Read data next value
  always_comb
  begin
    // Zero whenever no read was made, and for unmapped addresses
    next_regRdData = 16'h0000;
    if (regRd)
    begin
      if (hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR))
      begin
        // Next-page, reserved and selector bits come from the fixed pattern
        next_regRdData = advView;
      end
      else if (hitAddr(regAddr, autoneg_adv_pkg::CTRL_ADDR))
      begin
        // Restart bit reads one only during its pulse
        next_regRdData[autoneg_adv_pkg::RESTART_POS] = restartNeg;
      end
      else if (hitAddr(regAddr, autoneg_adv_pkg::STATUS_ADDR))
      begin
        // Outcome of the last restart
        next_regRdData[autoneg_adv_pkg::STAT_MODE_HI:autoneg_adv_pkg::STAT_MODE_LO] =
          lnk.resolvedMode;
        next_regRdData[autoneg_adv_pkg::STAT_VALID_POS] = lnk.resolvedValid;
      end
      else
      begin
        // Unmapped reads return zero; the bus never stalls
        next_regRdData = 16'h0000;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      regRdData <= 16'h0000;
    end
    else
    begin
      regRdData <= next_regRdData;
    end
  end

  // Checks on the register side; all sample at the rising edge and sleep in reset,
  // so an asynchronous reset in mid-run cannot leave a stale attempt behind
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Ability bits written are the ones read back
  chk_ability_write: assert property (
    wrAdv |=> advView[autoneg_adv_pkg::ABILITY_HI:autoneg_adv_pkg::ABILITY_LO]
              == $past(regWrData[autoneg_adv_pkg::ABILITY_HI:autoneg_adv_pkg::ABILITY_LO]))
    else $error("ability bits did not take the write");

  // Remote fault follows the write
  chk_fault_write: assert property (
    wrAdv |=> advView[autoneg_adv_pkg::REMOTE_FAULT_POS]
              == $past(regWrData[autoneg_adv_pkg::REMOTE_FAULT_POS]))
    else $error("remote fault bit did not take the write");

  // Read-only bits keep their fixed values in every read
  chk_fixed_bits: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR)
    |=> (regRdData & ~autoneg_adv_pkg::ADV_WRITE_MASK) == autoneg_adv_pkg::ADV_FIXED)
    else $error("read-only advertisement bits changed");

  // Next-page capability never reads one
  chk_next_page_zero: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR)
    |=> !regRdData[autoneg_adv_pkg::NEXT_PAGE_POS])
    else $error("next-page bit read as one");

  // Value after reset release is the documented reset pattern
  chk_reset_value: assert property (
    $past(rst) |-> advView == autoneg_adv_pkg::ADV_RESET)
    else $error("advertisement reset value wrong");

  // Read of the advertisement shows the full word one cycle later
  chk_read_word: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR) |=> regRdData == $past(advView))
    else $error("advertisement read data wrong");

  // Read data stands only in the cycle after the strobe
  chk_read_idle_zero: assert property (!regRd |=> regRdData == 16'h0000)
    else $error("read data present without a read");

  // Restart write gives one pulse, and the link moves on the next edge
  chk_restart_pulse: assert property (
    wrCtrl && regWrData[autoneg_adv_pkg::RESTART_POS]
    |=> restartNeg ##1 (!restartNeg || $past(wrCtrl)) && appliedAdvert == $past(advView))
    else $error("restart pulse or apply timing wrong");

  // An advertisement write alone leaves the link untouched
  chk_write_no_effect: assert property (
    wrAdv && !restartNeg |=> ##1 (appliedAdvert == $past(appliedAdvert, 2)) || $past(restartNeg))
    else $error("write reached the link without restart");

  // Storage never holds a bit outside the writable set
  chk_store_masked: assert property (
    (advStore & ~autoneg_adv_pkg::ADV_WRITE_MASK) == 16'h0000)
    else $error("read-only bit was stored");

  // Without an advertisement write the software view holds still
  chk_view_hold: assert property (
    !wrAdv |=> $stable(advView))
    else $error("advertisement changed without a write");

  // Restart only ever follows a control write with the restart bit
  chk_restart_source: assert property (
    restartNeg |-> $past(wrCtrl && regWrData[autoneg_adv_pkg::RESTART_POS]))
    else $error("restart pulse without a control write");

  // A lone restart write never stretches into a second cycle
  chk_restart_single: assert property (
    restartNeg |=> !restartNeg || $past(wrCtrl && regWrData[autoneg_adv_pkg::RESTART_POS]))
    else $error("restart pulse longer than one cycle");

  // Control read shows only the restart bit, as it stood at the strobe
  chk_ctrl_read: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::CTRL_ADDR)
    |=> regRdData[autoneg_adv_pkg::RESTART_POS] == $past(restartNeg)
        && $countones(regRdData) <= 1)
    else $error("control read data wrong");

  // Status read reports the last negotiation outcome
  chk_status_read: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::STATUS_ADDR)
    |=> regRdData[autoneg_adv_pkg::STAT_MODE_HI:autoneg_adv_pkg::STAT_MODE_LO]
          == $past(resolvedMode)
        && regRdData[autoneg_adv_pkg::STAT_VALID_POS] == $past(resolvedValid))
    else $error("status read data wrong");

  // Reads of unmapped addresses return zero
  chk_unmapped_read: assert property (
    regRd && !hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR)
    && !hitAddr(regAddr, autoneg_adv_pkg::CTRL_ADDR)
    && !hitAddr(regAddr, autoneg_adv_pkg::STATUS_ADDR)
    |=> regRdData == 16'h0000)
    else $error("unmapped read returned data");

  // The reserved bit never reads as one, whatever software wrote there
  chk_reserved_zero: assert property (
    regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR)
    |=> !regRdData[autoneg_adv_pkg::RESERVED_POS])
    else $error("reserved bit read as one");

  // The word on the link keeps the fixed read-only pattern
  chk_applied_fixed: assert property (
    (appliedAdvert & ~autoneg_adv_pkg::ADV_WRITE_MASK) == autoneg_adv_pkg::ADV_FIXED)
    else $error("applied word lost its fixed bits");

  // A negotiated mode is always one that was offered
  chk_mode_offered: assert property (
    resolvedValid |-> appliedAdvert[autoneg_adv_pkg::ABILITY_LO + int'(resolvedMode)])
    else $error("negotiated mode was not advertised");

  // With nothing shared the mode falls back to the lowest code
  chk_invalid_mode: assert property (
    !resolvedValid |-> resolvedMode == autoneg_adv_pkg::MODE_10_HALF)
    else $error("mode set without a common ability");

  // A write to the control register leaves the advertisement alone
  chk_ctrl_no_adv: assert property (
    wrCtrl |=> $stable(advStore))
    else $error("control write altered the advertisement");

  // A read right behind a write already returns the new abilities
  chk_write_then_read: assert property (
    wrAdv ##1 (regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR))
    |=> regRdData[autoneg_adv_pkg::ABILITY_HI:autoneg_adv_pkg::ABILITY_LO]
        == $past(regWrData[autoneg_adv_pkg::ABILITY_HI:autoneg_adv_pkg::ABILITY_LO], 2))
    else $error("read behind a write returned stale abilities");

  // Main scenarios
  cov_write_then_restart: cover property (
    wrAdv ##1 wrCtrl && regWrData[autoneg_adv_pkg::RESTART_POS] ##2 resolvedValid);
  cov_read_adv: cover property (regRd && hitAddr(regAddr, autoneg_adv_pkg::ADV_ADDR));
  cov_fallback_half: cover property (
    restartNeg ##1 resolvedValid && resolvedMode == autoneg_adv_pkg::MODE_100_HALF);
  cov_no_common: cover property (restartNeg ##1 !resolvedValid);
  cov_fast_full: cover property (
    restartNeg ##1 resolvedValid && resolvedMode == autoneg_adv_pkg::MODE_100_FULL);

endmodule

// ### autoneg_adv_pkg.sv
// What this block does
// - Ability bits 8..5 readable and writable
// - Cleared abilities steer negotiation to another technology
// - New advertisement applies only on negotiation restart
// - Register at 0x04, resets to 0x01E1
// - Bit 15 next-page capability, read-only zero
// - Bit 13 writable remote fault, clear at reset
// - Bits 8,7,6 offer 100FD, 100HD, 10FD
package autoneg_adv_pkg;

  // Management bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register addresses on the management port
  localparam logic [4:0] CTRL_ADDR   = 5'h00;
  localparam logic [4:0] ADV_ADDR    = 5'h04;
  localparam logic [4:0] STATUS_ADDR = 5'h10;

  // Advertisement layout: reset value, writable bits, fixed read-only bits
  localparam logic [15:0] ADV_RESET      = 16'h01E1;
  localparam logic [15:0] ADV_WRITE_MASK = 16'h21E0;
  localparam logic [15:0] ADV_FIXED      = 16'h0001;

  // Advertisement field positions
  localparam int NEXT_PAGE_POS    = 15;
  localparam int RESERVED_POS     = 14;
  localparam int REMOTE_FAULT_POS = 13;
  localparam int ABILITY_HI       = 8;
  localparam int ABILITY_LO       = 5;
  localparam int FAST_FULL_POS    = 8;
  localparam int FAST_HALF_POS    = 7;
  localparam int SLOW_FULL_POS    = 6;
  localparam int SLOW_HALF_POS    = 5;

  // Control register: self-clearing restart bit
  localparam int RESTART_POS = 9;

  // Status register fields
  localparam int STAT_MODE_HI   = 1;
  localparam int STAT_MODE_LO   = 0;
  localparam int STAT_VALID_POS = 2;

  // Negotiated technology, highest priority has the highest code
  typedef enum logic [1:0] {
    MODE_10_HALF  = 2'b00,
    MODE_10_FULL  = 2'b01,
    MODE_100_HALF = 2'b10,
    MODE_100_FULL = 2'b11
  } link_mode_t;

  // Visible advertisement word: writable bits from storage, rest fixed
  function automatic logic [15:0] composeAdvert(input logic [15:0] stored);
    return (stored & ADV_WRITE_MASK) | ADV_FIXED;
  endfunction

endpackage

// ### adv_link_if.sv
`timescale 1ns/1ps
// Carries the pending advertisement and restart into the apply stage
interface adv_link_if;
  logic [15:0]                  pendingAdvert;   // Software view, not yet applied
  logic                         restart;         // One-cycle negotiation restart
  logic [3:0]                   partnerAbility;  // Partner abilities, 100FD at bit 3
  logic [15:0]                  appliedAdvert;   // Word offered on the link
  autoneg_adv_pkg::link_mode_t  resolvedMode;    // Best common technology
  logic                         resolvedValid;   // A common technology exists

  // Register side drives pending state and restart
  modport regs (
    output pendingAdvert,
    output restart,
    output partnerAbility,
    input  appliedAdvert,
    input  resolvedMode,
    input  resolvedValid
  );

  // Apply side latches and resolves on restart
  modport apply (
    input  pendingAdvert,
    input  restart,
    input  partnerAbility,
    output appliedAdvert,
    output resolvedMode,
    output resolvedValid
  );
endinterface

// ### adv_apply.sv
`timescale 1ns/1ps
// Latches the advertisement on restart and picks the best shared technology
module adv_apply (
  input  wire logic clk,
  input  wire logic rst,
  adv_link_if.apply lnk
);

  logic [15:0]                 appliedAdvert;       // Word on the link
  logic [15:0]                 next_appliedAdvert;
  autoneg_adv_pkg::link_mode_t resolvedMode;        // Last negotiated mode
  autoneg_adv_pkg::link_mode_t next_resolvedMode;
  logic                        resolvedValid;       // Last negotiation found a match
  logic                        next_resolvedValid;
  logic [3:0]                  common;              // Abilities both ends share

  // Highest common ability wins; cleared bits simply drop out
  function automatic autoneg_adv_pkg::link_mode_t pickMode(input logic [3:0] shared);
    if (shared[3])
      return autoneg_adv_pkg::MODE_100_FULL;
    else if (shared[2])
      return autoneg_adv_pkg::MODE_100_HALF;
    else if (shared[1])
      return autoneg_adv_pkg::MODE_10_FULL;
    else
      return autoneg_adv_pkg::MODE_10_HALF;
  endfunction

  // Next values: nothing moves except on a restart
  always_comb
  begin
    common = lnk.pendingAdvert[autoneg_adv_pkg::ABILITY_HI:autoneg_adv_pkg::ABILITY_LO]
           & lnk.partnerAbility;
    next_appliedAdvert = appliedAdvert;
    next_resolvedMode  = resolvedMode;
    next_resolvedValid = resolvedValid;
    if (lnk.restart)
    begin
      next_appliedAdvert = lnk.pendingAdvert;
      next_resolvedMode  = pickMode(common);
      next_resolvedValid = |common;
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      appliedAdvert <= autoneg_adv_pkg::ADV_RESET;
      resolvedMode  <= autoneg_adv_pkg::MODE_10_HALF;
      resolvedValid <= 1'b0;
    end
    else
    begin
      appliedAdvert <= next_appliedAdvert;
      resolvedMode  <= next_resolvedMode;
      resolvedValid <= next_resolvedValid;
    end
  end

  assign lnk.appliedAdvert = appliedAdvert;
  assign lnk.resolvedMode  = resolvedMode;
  assign lnk.resolvedValid = resolvedValid;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Without a restart the link keeps the old word
  chk_hold_until_restart: assert property (!lnk.restart |=> $stable(appliedAdvert))
    else $error("applied advertisement changed without restart");

  // A restart copies the pending word
  chk_apply_on_restart: assert property (
    lnk.restart |=> appliedAdvert == $past(lnk.pendingAdvert))
    else $error("restart did not apply pending advertisement");

  // Shared 100 full duplex always wins
  chk_pick_fast_full: assert property (
    lnk.restart && lnk.pendingAdvert[autoneg_adv_pkg::FAST_FULL_POS] && lnk.partnerAbility[3]
    |=> resolvedValid && resolvedMode == autoneg_adv_pkg::MODE_100_FULL)
    else $error("100 full duplex not chosen");

  // A cleared 100 full duplex ability is never the outcome
  chk_skip_cleared: assert property (
    lnk.restart && !lnk.pendingAdvert[autoneg_adv_pkg::FAST_FULL_POS]
    |=> resolvedMode != autoneg_adv_pkg::MODE_100_FULL)
    else $error("cleared ability was negotiated");

endmodule

// ### link_partner_model.sv
`timescale 1ns/1ps
// Far end of the link: offers its abilities as a steady level and keeps the
// word it last heard, so the bench can see what actually went on the wire.
module link_partner_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  abilityWant,     // Abilities the bench wants offered
  input  wire logic        restartNeg,      // Restart pulse from the device
  input  wire logic [15:0] appliedAdvert,   // Word the device offers
  output logic      [3:0]  partnerAbility,  // Abilities seen by the device
  output logic      [15:0] heardAdvert      // Word captured after a restart
);
  logic [3:0]  next_partnerAbility;  // Registered so it never moves mid-edge
  logic [15:0] next_heardAdvert;     // Capture of the offered word
  logic        heardPending;         // Restart seen, word lands one cycle later
  logic        next_heardPending;

  // Next state: the offered word settles one cycle after the restart pulse
  always_comb
  begin
    next_partnerAbility = abilityWant;
    next_heardPending   = restartNeg;
    next_heardAdvert    = heardPending ? appliedAdvert : heardAdvert;
  end

  // State registers; reset leaves the partner offering nothing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      partnerAbility <= 4'h0;
      heardPending   <= 1'b0;
      heardAdvert    <= 16'h0000;
    end
    else
    begin
      partnerAbility <= next_partnerAbility;
      heardPending   <= next_heardPending;
      heardAdvert    <= next_heardAdvert;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // One ordinary case: advertisement written, partner offer, expected results
  typedef struct packed {
    logic [15:0] wrVal;
    logic [3:0]  partner;
    logic [15:0] expRead;
    logic [1:0]  expMode;
    logic        expValid;
  } row_t;
  localparam row_t ROWS [7] = '{
    '{16'hFFFF, 4'hF, 16'h21E1, 2'h3, 1'b1},  // All writable bits, fastest mode wins
    '{16'h00E1, 4'hF, 16'h00E1, 2'h2, 1'b1},  // Fast full duplex withdrawn
    '{16'h0060, 4'hF, 16'h0061, 2'h1, 1'b1},  // Only slow modes left
    '{16'h0020, 4'h1, 16'h0021, 2'h0, 1'b1},  // Lowest common mode
    '{16'h0100, 4'h7, 16'h0101, 2'h0, 1'b0},  // Nothing shared
    '{16'h2080, 4'h4, 16'h2081, 2'h2, 1'b1},  // Remote fault plus fast half duplex
    '{16'h1E1E, 4'hF, 16'h0001, 2'h0, 1'b0}   // Only read-only bits written
  };
  logic                        clk;             // 40 MHz bench clock
  logic                        rst;             // Asynchronous reset
  logic [4:0]                  regAddr;         // Register address
  logic [15:0]                 regWrData;       // Write data
  logic                        regWr;           // Write strobe
  logic                        regRd;           // Read strobe
  logic [15:0]                 regRdData;       // Read data, one cycle after the strobe
  logic [3:0]                  partnerAbility;  // Partner offer into the device
  logic [3:0]                  abilityWant;     // Offer requested of the partner
  logic                        restartNeg;      // Restart pulse
  logic [15:0]                 appliedAdvert;   // Word on the link
  logic [15:0]                 heardAdvert;     // Word the partner captured
  autoneg_adv_pkg::link_mode_t resolvedMode;    // Negotiated technology
  logic                        resolvedValid;   // A common technology exists
  int                          fails;           // Mismatches so far
  int                          checksDone;      // Comparisons so far
  logic [15:0]                 prevApplied;     // Word that must hold until restart
  logic [15:0]                 rdWord;          // Captured read data

  autoneg_advertisement_register autoneg_advertisement_register_i (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .partnerAbility(partnerAbility),
    .restartNeg(restartNeg), .appliedAdvert(appliedAdvert), .resolvedMode(resolvedMode),
    .resolvedValid(resolvedValid));
  link_partner_model link_partner_model_i (
    .clk(clk), .rst(rst), .abilityWant(abilityWant), .restartNeg(restartNeg),
    .appliedAdvert(appliedAdvert), .partnerAbility(partnerAbility),
    .heardAdvert(heardAdvert));

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp, input string what);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic checkMode(input autoneg_adv_pkg::link_mode_t got, input logic [1:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: mode got %b expected %b", $time, got, exp);
    end
  endtask

  // The write strobe is left high so a following access can go back to back
  task automatic busWr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regRd     <= 1'b0;
    regAddr   <= a;
    regWrData <= d;
  endtask

  task automatic idle();
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask

  // Read: the idle edge takes the strobe, data stands in the cycle after it
  task automatic readWord(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regWr   <= 1'b0;
    regAddr <= a;
    idle();
    #1 d = regRdData;
  endtask

  task automatic readCheck(input logic [4:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    readWord(a, d);
    checkWord(d, exp, what);
  endtask

  // Restart, then the applied word and result land one cycle after the pulse
  task automatic restart(input logic [15:0] expApplied);
    busWr(autoneg_adv_pkg::CTRL_ADDR, 16'h0200);
    idle();
    #1 checkBit(restartNeg, 1'b1, "restart pulse");
    @(posedge clk);
    #1 checkBit(restartNeg, 1'b0, "restart pulse end");
    checkWord(appliedAdvert, expApplied, "applied word");
    // The partner captures the word one cycle after the link moves
    @(posedge clk);
    #1 checkWord(heardAdvert, expApplied, "partner heard");
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog sized well past the expected run of about 110 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    results();
  end

  initial
  begin
    {regAddr, regWrData, regWr, regRd, abilityWant} = '0;
    rst = 1'b1;
    fails = 0;
    checksDone = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1 checkWord(appliedAdvert, 16'h01E1, "applied after reset");
    checkBit(resolvedValid, 1'b0, "valid after reset");
    readCheck(autoneg_adv_pkg::ADV_ADDR, 16'h01E1, "adv reset");
    @(posedge clk);
    #1 checkWord(regRdData, 16'h0000, "read data released");
    prevApplied = 16'h01E1;
    // Ordinary cases from the table
    foreach (ROWS[i])
    begin
      @(posedge clk);
      abilityWant <= ROWS[i].partner;
      // Read straight behind the write, with no idle cycle between
      busWr(autoneg_adv_pkg::ADV_ADDR, ROWS[i].wrVal);
      readCheck(autoneg_adv_pkg::ADV_ADDR, ROWS[i].expRead, "adv readback");
      checkWord(appliedAdvert, prevApplied, "applied before restart");
      restart(ROWS[i].expRead);
      checkMode(resolvedMode, ROWS[i].expMode);
      checkBit(resolvedValid, ROWS[i].expValid, "common mode");
      readCheck(autoneg_adv_pkg::STATUS_ADDR, {13'h0000, ROWS[i].expValid, ROWS[i].expMode},
                "status");
      prevApplied = ROWS[i].expRead;
    end
    // Unmapped address: write ignored, read returns zero
    busWr(5'h1F, 16'hFFFF);
    idle();
    readCheck(5'h1F, 16'h0000, "unmapped read");
    readCheck(autoneg_adv_pkg::ADV_ADDR, 16'h0001, "adv after unmapped write");
    readCheck(autoneg_adv_pkg::CTRL_ADDR, 16'h0000, "control idle");
    // Read-modify-write setting bits 13 and 8, restart back to back with the write
    @(posedge clk);
    abilityWant <= 4'hF;
    readWord(autoneg_adv_pkg::ADV_ADDR, rdWord);
    busWr(autoneg_adv_pkg::ADV_ADDR, rdWord | 16'h2100);
    restart(16'h2101);
    checkMode(resolvedMode, 2'h3);
    // Reset in mid-run restores the defaults
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 checkWord(appliedAdvert, 16'h01E1, "applied in reset");
    checkMode(resolvedMode, 2'h0);
    checkBit(resolvedValid, 1'b0, "valid in reset");
    @(posedge clk);
    rst <= 1'b0;
    readCheck(autoneg_adv_pkg::ADV_ADDR, 16'h01E1, "adv after reset");
    results();
  end
endmodule
